// ==== vpe_bank.sv ====
/*
 * Voltage protection element bank: phase under/overvoltage, neutral and
 * negative-sequence overvoltage, auxiliary under/overvoltage and two
 * volts-per-hertz elements, with an Avalon-MM settings slave.
 * Assumes phasor inputs and frequency are synchronous to i_clock and
 * refreshed by the estimation front end; in delta mode the three channels
 * carry phase-to-phase phasors.
 */
`timescale 1ns/1ps
// Overview of operation
// (RL1) Phase undervoltage uses phase-ground or phase-phase; delta forces phase-phase.
// (RL2) Phase undervoltage drops pickup and clears timing at once above dropout.
// (RL3) Undervoltage delay is the shortest operate time for any curve.
// (RL4) Undervoltage blocked below minimum voltage; zero minimum lets dead source trip.
// (RL5) Phase overvoltage is instantaneous or definite time on phase-phase voltage.
// (RL6) Neutral overvoltage uses computed 3V0, pickup per unit of phase nominal.
// (RL7) Software enables neutral overvoltage only with wye-connected transformers.
// (RL8) Auxiliary undervoltage times below pickup, per unit of auxiliary nominal.
// (RL9) Auxiliary undervoltage has phase undervoltage curves, instant reset, minimum block.
// (RL10) Auxiliary overvoltage picks up above pickup, per unit of auxiliary nominal.
// (RL11) Two independent volts-per-hertz elements with own settings and outputs.
// (RL12) Volts-per-hertz uses largest phase voltage, auxiliary only without phases.
// (RL13) No voltage on selected inputs forces volts-per-hertz to zero.
// (RL14) One per unit volts-per-hertz is selected nominal voltage over nominal frequency.
// (RL15) Phases win over auxiliary; all phases zero gives zero.
// (RL16) Volts-per-hertz accumulator decays linearly to zero in the reset time.
// (RL17) Definite time operates after multiplier seconds; zero is instantaneous. The code counts the multiplier in 10 ms ticks.
// (RL18) Curve A: multiplier over squared ratio minus one, above pickup.
// (RL19) Curve B: multiplier over ratio minus one, above pickup.
// (RL20) Curve C: multiplier over square root of ratio minus one.
// (RL21) Undervoltage delay spans zero to six hundred seconds in 10 ms steps.
// (RL22) Elements accumulate time fractions, pickup at once, operate at the threshold.
// (RL23) Blocked or disabled elements stay inactive with outputs low.
module vpe_bank #(
    parameter int TICK_CYCLES = vpe_pkg::TICK_CYCLES_DFLT
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic signed [15:0] i_va_re,
    input wire logic signed [15:0] i_va_im,
    input wire logic signed [15:0] i_vb_re,
    input wire logic signed [15:0] i_vb_im,
    input wire logic signed [15:0] i_vc_re,
    input wire logic signed [15:0] i_vc_im,
    input wire logic [15:0] i_aux_voltage_input,
    input wire logic [15:0] i_freq,
    input wire logic [7:0] i_block,
    output logic [7:0] o_pickup,
    output logic [7:0] o_operate
);
    localparam int W = vpe_pkg::ACC_W;
    localparam int NE = vpe_pkg::NUM_ELEM;

    logic [15:0] set_r [NE][4];
    logic [15:0] vnom_ph_r;
    logic [15:0] vnom_aux_r;
    logic [15:0] fnom_r;
    logic [15:0] cfg_r;
    logic ack_r;
    logic [31:0] tick_cnt_r;
    logic tick;

    function automatic logic [15:0] f_mag(input logic signed [17:0] re,
                                         input logic signed [17:0] im);
        logic [17:0] ar;
        logic [17:0] ai;
        logic [17:0] hi;
        logic [17:0] lo;
        logic [19:0] s;
        ar = re[17] ? 18'(-re) : 18'(re);
        ai = im[17] ? 18'(-im) : 18'(im);
        hi = (ar > ai) ? ar : ai;
        lo = (ar > ai) ? ai : ar;
        // Alpha-max beta-min estimate, within a few percent of the true magnitude
        s = 20'(hi) + 20'(lo >> 2) + 20'(lo >> 3);
        return (s > 20'h0FFFF) ? 16'hFFFF : s[15:0];
    endfunction

    function automatic logic [15:0] f_min3(input logic [15:0] a, input logic [15:0] b,
                                          input logic [15:0] c);
        logic [15:0] t;
        t = (a < b) ? a : b;
        return (t < c) ? t : c;
    endfunction

    function automatic logic [15:0] f_max3(input logic [15:0] a, input logic [15:0] b,
                                          input logic [15:0] c);
        logic [15:0] t;
        t = (a > b) ? a : b;
        return (t > c) ? t : c;
    endfunction

    function automatic logic [31:0] f_pu2v(input logic [15:0] pu, input logic [15:0] vnom);
        logic [31:0] prod;
        prod = pu * vnom;
        return {16'h0000, prod[23:8]};
    endfunction

    function automatic logic [15:0] f_isqrt(input logic [31:0] x);
        logic [15:0] r;
        logic [15:0] t;
        r = 16'h0000;
        for (int i = 15; i >= 0; i--)
        begin
            t = r | (16'h0001 << i);
            if (32'(t) * 32'(t) <= x)
            begin
                r = t;
            end
        end
        return r;
    endfunction

    // Increment per tick; inverse curves integrate the ratio excess against the threshold
    function automatic logic [W-1:0] f_inc(input vpe_pkg::vpe_curve_t cv, input logic is_uv,
                                           input logic [31:0] m, input logic [31:0] p);
        logic [W-1:0] r;
        unique case (cv)
            vpe_pkg::VPE_CURVE_DEF: r = W'(1); // RL17
            vpe_pkg::VPE_CURVE_A: r = is_uv ? W'(p - m) : W'(64'(m) * m - 64'(p) * p); // RL18
            vpe_pkg::VPE_CURVE_B: r = is_uv ? W'(p - m) : W'(m - p); // RL19
            vpe_pkg::VPE_CURVE_C: r = is_uv ? W'(p - m) : W'(f_isqrt(m) - f_isqrt(p)); // RL20
        endcase
        return r;
    endfunction

    function automatic logic [W-1:0] f_thr(input vpe_pkg::vpe_curve_t cv, input logic is_uv,
                                           input logic [31:0] p, input logic [15:0] d);
        logic [W-1:0] r;
        unique case (cv)
            vpe_pkg::VPE_CURVE_DEF: r = W'(d);
            vpe_pkg::VPE_CURVE_A: r = is_uv ? W'(d) * W'(p) : W'(d) * W'(p) * W'(p);
            vpe_pkg::VPE_CURVE_B: r = W'(d) * W'(p);
            vpe_pkg::VPE_CURVE_C: r = is_uv ? W'(d) * W'(p) : W'(d) * W'(f_isqrt(p));
        endcase
        return r;
    endfunction

    // Time base
    assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

    always_ff @(posedge i_clock)
    begin
        if (i_rst || tick)
        begin
            tick_cnt_r <= 32'h00000000;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + 32'h00000001;
        end
    end

    // Measured quantities
    logic signed [17:0] a_re, a_im, b_re, b_im, c_re, c_im;
    logic [15:0] mag_a, mag_b, mag_c, mag_ab, mag_bc, mag_ca;
    logic [15:0] mag_3v0, mag_v2;
    logic signed [27:0] v2_re_q, v2_im_q;
    logic [23:0] v2_scaled;
    logic delta;

    always_comb
    begin
        delta = cfg_r[vpe_pkg::CFG_DELTA_BIT];
        a_re = 18'(i_va_re);
        a_im = 18'(i_va_im);
        b_re = 18'(i_vb_re);
        b_im = 18'(i_vb_im);
        c_re = 18'(i_vc_re);
        c_im = 18'(i_vc_im);
        mag_a = f_mag(a_re, a_im);
        mag_b = f_mag(b_re, b_im);
        mag_c = f_mag(c_re, c_im);
        // Delta channels already carry line voltages; wye ones are differenced
        mag_ab = delta ? mag_a : f_mag(a_re - b_re, a_im - b_im); // RL5
        mag_bc = delta ? mag_b : f_mag(b_re - c_re, b_im - c_im); // RL5
        mag_ca = delta ? mag_c : f_mag(c_re - a_re, c_im - a_im); // RL5
        mag_3v0 = f_mag(a_re + b_re + c_re, a_im + b_im + c_im); // RL6
        v2_re_q = (28'(a_re) <<< 10) - (28'(b_re) <<< 9) - (28'(c_re) <<< 9)
                  + vpe_pkg::SIN120_Q10 * 28'(b_im) - vpe_pkg::SIN120_Q10 * 28'(c_im);
        v2_im_q = (28'(a_im) <<< 10) - (28'(b_im) <<< 9) - (28'(c_im) <<< 9)
                  - vpe_pkg::SIN120_Q10 * 28'(b_re) + vpe_pkg::SIN120_Q10 * 28'(c_re);
        // Divide 3V2 by three with 85/256
        v2_scaled = f_mag(18'(v2_re_q >>> 10), 18'(v2_im_q >>> 10)) * 8'h55;
        mag_v2 = v2_scaled[23:8];
    end

    // Per-element operating quantity, threshold and pickup condition
    logic [31:0] m_a [NE];
    logic [31:0] p_a [NE];
    logic [31:0] minv_a [NE];
    logic pk_a [NE];
    logic [W-1:0] inc_a [NE];
    logic [W-1:0] thr_a [NE];
    logic [15:0] rst_a [NE];
    logic [15:0] uv_v;
    logic [15:0] vhz_v;
    logic [15:0] vhz_nom;
    logic [15:0] delay_ph_uv;
    logic [15:0] delay_aux_uv;
    logic phase_cfg;
    logic aux_cfg;

    always_comb
    begin
        phase_cfg = cfg_r[vpe_pkg::CFG_PHASE_BIT];
        aux_cfg = cfg_r[vpe_pkg::CFG_AUX_BIT];
        uv_v = (delta || set_r[vpe_pkg::EL_PH_UV][vpe_pkg::FLD_CTRL][vpe_pkg::CTRL_PHPH_BIT])
               ? f_min3(mag_ab, mag_bc, mag_ca) : f_min3(mag_a, mag_b, mag_c); // RL1
        vhz_v = phase_cfg ? f_max3(mag_a, mag_b, mag_c)
                : (aux_cfg ? i_aux_voltage_input : 16'h0000); // RL12 RL15
        vhz_nom = phase_cfg ? vnom_ph_r : vnom_aux_r; // RL14
        delay_ph_uv = (set_r[vpe_pkg::EL_PH_UV][vpe_pkg::FLD_DELAY] > vpe_pkg::DELAY_MAX)
                      ? vpe_pkg::DELAY_MAX : set_r[vpe_pkg::EL_PH_UV][vpe_pkg::FLD_DELAY]; // RL21
        delay_aux_uv = (set_r[vpe_pkg::EL_AUX_UV][vpe_pkg::FLD_DELAY] > vpe_pkg::DELAY_MAX)
                       ? vpe_pkg::DELAY_MAX : set_r[vpe_pkg::EL_AUX_UV][vpe_pkg::FLD_DELAY];
        for (int e = 0; e < NE; e++)
        begin
            m_a[e] = 32'h00000000;
            p_a[e] = 32'h00000000;
            minv_a[e] = 32'h00000000;
            rst_a[e] = 16'h0000;
        end
        m_a[vpe_pkg::EL_PH_UV] = {16'h0000, uv_v};
        p_a[vpe_pkg::EL_PH_UV] = f_pu2v(set_r[vpe_pkg::EL_PH_UV][vpe_pkg::FLD_PICKUP], vnom_ph_r);
        minv_a[vpe_pkg::EL_PH_UV] = f_pu2v(set_r[vpe_pkg::EL_PH_UV][vpe_pkg::FLD_EXTRA],
                                           vnom_ph_r);
        m_a[vpe_pkg::EL_PH_OV] = {16'h0000, f_max3(mag_ab, mag_bc, mag_ca)}; // RL5
        p_a[vpe_pkg::EL_PH_OV] = f_pu2v(set_r[vpe_pkg::EL_PH_OV][vpe_pkg::FLD_PICKUP], vnom_ph_r);
        m_a[vpe_pkg::EL_ZS_OV] = {16'h0000, mag_3v0};
        p_a[vpe_pkg::EL_ZS_OV] = f_pu2v(set_r[vpe_pkg::EL_ZS_OV][vpe_pkg::FLD_PICKUP],
                                        vnom_ph_r); // RL6
        m_a[vpe_pkg::EL_NS_OV] = {16'h0000, mag_v2};
        p_a[vpe_pkg::EL_NS_OV] = f_pu2v(set_r[vpe_pkg::EL_NS_OV][vpe_pkg::FLD_PICKUP], vnom_ph_r);
        m_a[vpe_pkg::EL_AUX_UV] = {16'h0000, i_aux_voltage_input};
        p_a[vpe_pkg::EL_AUX_UV] = f_pu2v(set_r[vpe_pkg::EL_AUX_UV][vpe_pkg::FLD_PICKUP],
                                         vnom_aux_r); // RL8
        minv_a[vpe_pkg::EL_AUX_UV] = f_pu2v(set_r[vpe_pkg::EL_AUX_UV][vpe_pkg::FLD_EXTRA],
                                            vnom_aux_r); // RL9
        m_a[vpe_pkg::EL_AUX_OV] = {16'h0000, i_aux_voltage_input};
        p_a[vpe_pkg::EL_AUX_OV] = f_pu2v(set_r[vpe_pkg::EL_AUX_OV][vpe_pkg::FLD_PICKUP],
                                         vnom_aux_r); // RL10
        for (int e = vpe_pkg::EL_VHZ1; e <= vpe_pkg::EL_VHZ2; e++)
        begin
            // Cross-multiplied: V*Fnom against pickup*Vnom*F avoids a divider
            m_a[e] = (i_freq == 16'h0000) ? 32'h00000000 : vhz_v * fnom_r; // RL13 RL14
            p_a[e] = 16'(f_pu2v(set_r[e][vpe_pkg::FLD_PICKUP], vhz_nom)) * i_freq; // RL14
            rst_a[e] = set_r[e][vpe_pkg::FLD_EXTRA]; // RL16
        end
        for (int e = 0; e < NE; e++)
        begin
            if (e == vpe_pkg::EL_PH_UV || e == vpe_pkg::EL_AUX_UV)
            begin
                pk_a[e] = (m_a[e] < p_a[e]) && (m_a[e] >= minv_a[e]); // RL4 RL9 RL2
            end
            else
            begin
                pk_a[e] = (m_a[e] > p_a[e]) && (m_a[e] != 32'h00000000); // RL10 RL13
            end
        end
        // Undervoltage curve fill is at most one delay step per tick
        inc_a[vpe_pkg::EL_PH_UV] = f_inc(vpe_curve_sel(vpe_pkg::EL_PH_UV), 1'b1,
                                         m_a[vpe_pkg::EL_PH_UV], p_a[vpe_pkg::EL_PH_UV]);
        thr_a[vpe_pkg::EL_PH_UV] = f_thr(vpe_curve_sel(vpe_pkg::EL_PH_UV), 1'b1,
                                         p_a[vpe_pkg::EL_PH_UV], delay_ph_uv); // RL3
        inc_a[vpe_pkg::EL_AUX_UV] = f_inc(vpe_curve_sel(vpe_pkg::EL_AUX_UV), 1'b1,
                                          m_a[vpe_pkg::EL_AUX_UV], p_a[vpe_pkg::EL_AUX_UV]);
        thr_a[vpe_pkg::EL_AUX_UV] = f_thr(vpe_curve_sel(vpe_pkg::EL_AUX_UV), 1'b1,
                                          p_a[vpe_pkg::EL_AUX_UV], delay_aux_uv); // RL9
        for (int e = vpe_pkg::EL_PH_OV; e <= vpe_pkg::EL_NS_OV; e++)
        begin
            inc_a[e] = W'(1); // RL5
            thr_a[e] = W'(set_r[e][vpe_pkg::FLD_DELAY]);
        end
        inc_a[vpe_pkg::EL_AUX_OV] = W'(1);
        thr_a[vpe_pkg::EL_AUX_OV] = W'(set_r[vpe_pkg::EL_AUX_OV][vpe_pkg::FLD_DELAY]);
        for (int e = vpe_pkg::EL_VHZ1; e <= vpe_pkg::EL_VHZ2; e++)
        begin
            inc_a[e] = f_inc(vpe_curve_sel(e), 1'b0, m_a[e], p_a[e]);
            thr_a[e] = f_thr(vpe_curve_sel(e), 1'b0, p_a[e], set_r[e][vpe_pkg::FLD_DELAY]);
        end
    end

    function automatic vpe_pkg::vpe_curve_t vpe_curve_sel(input int e);
        return vpe_pkg::vpe_curve_t'(set_r[e][vpe_pkg::FLD_CTRL][vpe_pkg::CTRL_CURVE_LSB +: 2]);
    endfunction

    // Element timers, one per element, each with its own settings
    genvar g;
    generate
        for (g = 0; g < NE; g++)
        begin : g_elem
            vpe_timer #(
                .W(W)
            ) u_timer (
                .i_clock(i_clock),
                .i_rst(i_rst),
                .i_tick(tick),
                .i_active(set_r[g][vpe_pkg::FLD_CTRL][vpe_pkg::CTRL_EN_BIT] && !i_block[g]), // RL23
                .i_picked(pk_a[g]),
                .i_inc(inc_a[g]),
                .i_thr(thr_a[g]),
                .i_reset_ticks(rst_a[g]),
                .o_pickup(o_pickup[g]),
                .o_operate(o_operate[g]) // RL11
            );
        end
    endgenerate

    // Avalon-MM slave: one wait state, write lands on the edge that sees waitrequest low
    logic req;
    logic elem_hit;
    logic [2:0] el_idx;
    logic [1:0] fld_idx;
    logic [31:0] rd_mux;

    function automatic logic [15:0] f_merge(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
        return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    always_comb
    begin
        req = i_avs_read || i_avs_write;
        elem_hit = !i_avs_address[7];
        el_idx = i_avs_address[6:4];
        fld_idx = i_avs_address[3:2];
        o_avs_waitrequest = req && !ack_r;
        rd_mux = 32'h00000000;
        if (elem_hit)
        begin
            rd_mux = {16'h0000, set_r[el_idx][fld_idx]};
        end
        else
        begin
            unique case ({i_avs_address[7:2], 2'b00})
                vpe_pkg::OFS_VNOM_PH: rd_mux = {16'h0000, vnom_ph_r};
                vpe_pkg::OFS_VNOM_AUX: rd_mux = {16'h0000, vnom_aux_r};
                vpe_pkg::OFS_FNOM: rd_mux = {16'h0000, fnom_r};
                vpe_pkg::OFS_CFG: rd_mux = {16'h0000, cfg_r};
                vpe_pkg::OFS_STATUS: rd_mux = {16'h0000, o_operate, o_pickup};
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            ack_r <= 1'b0;
            o_avs_readdata <= 32'h00000000;
        end
        else
        begin
            ack_r <= req && !ack_r;
            if (i_avs_read && !ack_r)
            begin
                o_avs_readdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            for (int e = 0; e < NE; e++)
            begin
                for (int f = 0; f < 4; f++)
                begin
                    set_r[e][f] <= vpe_pkg::SET_RST;
                end
            end
            vnom_ph_r <= vpe_pkg::VNOM_PH_RST;
            vnom_aux_r <= vpe_pkg::VNOM_AUX_RST;
            fnom_r <= vpe_pkg::FNOM_RST;
            cfg_r <= vpe_pkg::CFG_RST;
        end
        else if (i_avs_write && ack_r)
        begin
            if (elem_hit)
            begin
                set_r[el_idx][fld_idx] <= f_merge(set_r[el_idx][fld_idx], i_avs_writedata,
                                                  i_avs_byteenable);
            end
            else if ({i_avs_address[7:2], 2'b00} == vpe_pkg::OFS_VNOM_PH)
            begin
                vnom_ph_r <= f_merge(vnom_ph_r, i_avs_writedata, i_avs_byteenable);
            end
            else if ({i_avs_address[7:2], 2'b00} == vpe_pkg::OFS_VNOM_AUX)
            begin
                vnom_aux_r <= f_merge(vnom_aux_r, i_avs_writedata, i_avs_byteenable);
            end
            else if ({i_avs_address[7:2], 2'b00} == vpe_pkg::OFS_FNOM)
            begin
                fnom_r <= f_merge(fnom_r, i_avs_writedata, i_avs_byteenable);
            end
            else if ({i_avs_address[7:2], 2'b00} == vpe_pkg::OFS_CFG)
            begin
                // Neutral element is meaningful only with wye banks; software must keep to that
                cfg_r <= f_merge(cfg_r, i_avs_writedata, i_avs_byteenable); // RL7
            end
        end
    end

endmodule // vpe_bank

// ==== vpe_pkg.sv ====
/*
 * Constants shared by the voltage protection element bank: register map,
 * reset values, curve codes and time base figures.
 * Assumes a 25 MHz processing clock and 32-bit Avalon-MM register access.
 */
package vpe_pkg;

    localparam int CLK_HZ = 25000000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES_DFLT = CLK_HZ / 1000 * TICK_MS;
    localparam logic [15:0] DELAY_MAX = 16'hEA60;

    localparam int NUM_ELEM = 8;
    localparam int ACC_W = 96;

    localparam int EL_PH_UV = 0;
    localparam int EL_PH_OV = 1;
    localparam int EL_ZS_OV = 2;
    localparam int EL_NS_OV = 3;
    localparam int EL_AUX_UV = 4;
    localparam int EL_AUX_OV = 5;
    localparam int EL_VHZ1 = 6;
    localparam int EL_VHZ2 = 7;

    localparam logic [1:0] FLD_CTRL = 2'h0;
    localparam logic [1:0] FLD_PICKUP = 2'h1;
    localparam logic [1:0] FLD_DELAY = 2'h2;
    localparam logic [1:0] FLD_EXTRA = 2'h3;

    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_CURVE_LSB = 1;
    localparam int CTRL_PHPH_BIT = 3;

    localparam logic [7:0] OFS_VNOM_PH = 8'h80;
    localparam logic [7:0] OFS_VNOM_AUX = 8'h84;
    localparam logic [7:0] OFS_FNOM = 8'h88;
    localparam logic [7:0] OFS_CFG = 8'h8C;
    localparam logic [7:0] OFS_STATUS = 8'h90;

    localparam int CFG_DELTA_BIT = 0;
    localparam int CFG_PHASE_BIT = 1;
    localparam int CFG_AUX_BIT = 2;

    localparam logic [15:0] SET_RST = 16'h0000;
    localparam logic [15:0] VNOM_PH_RST = 16'h0042;
    localparam logic [15:0] VNOM_AUX_RST = 16'h0042;
    localparam logic [15:0] FNOM_RST = 16'h1770;
    localparam logic [15:0] CFG_RST = 16'h0002;

    localparam logic signed [27:0] SIN120_Q10 = 28'sh0000377;

    typedef enum logic [1:0] {
        VPE_CURVE_DEF = 2'h0,
        VPE_CURVE_A = 2'h1,
        VPE_CURVE_B = 2'h2,
        VPE_CURVE_C = 2'h3
    } vpe_curve_t;

endpackage

// ==== vpe_timer.sv ====
/*
 * One timed protection element: accumulates operate-time fractions while
 * picked up, trips at the threshold, resets at once or linearly.
 * Assumes one tick pulse per 10 ms time step from the parent.
 */
`timescale 1ns/1ps
module vpe_timer #(
    parameter int W = 96
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_tick,
    input wire logic i_active,
    input wire logic i_picked,
    input wire logic [W-1:0] i_inc,
    input wire logic [W-1:0] i_thr,
    input wire logic [15:0] i_reset_ticks,
    output logic o_pickup,
    output logic o_operate
);
    logic [W-1:0] acc_r;
    logic [W-1:0] scale;
    logic [W-1:0] cap;
    logic [W-1:0] step;
    logic [W-1:0] sum;
    logic linear;

    // Linear reset scales the fill by the reset time so the decay needs no divider
    always_comb
    begin
        linear = (i_reset_ticks != 16'h0000);
        scale = linear ? W'(i_reset_ticks) : W'(1);
        cap = i_thr * scale;
        step = i_inc * scale;
        sum = acc_r + step;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst || !i_active)
        begin
            acc_r <= '0; // RL23
        end
        else if (i_picked)
        begin
            if (i_tick)
            begin
                acc_r <= (sum < acc_r || sum > cap) ? cap : sum; // RL22
            end
        end
        else if (linear)
        begin
            if (i_tick)
            begin
                acc_r <= (acc_r > i_thr) ? acc_r - i_thr : '0; // RL16
            end
        end
        else
        begin
            acc_r <= '0; // RL2
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_pickup <= 1'b0;
            o_operate <= 1'b0;
        end
        else
        begin
            o_pickup <= i_active && i_picked; // RL22
            o_operate <= i_active && i_picked && (acc_r >= cap); // RL22
        end
    end

endmodule // vpe_timer

// ==== vpe_bank_properties.sv ====
/* Port checker for vpe_bank, bound below.
   Assumes i_rst synchronous and active high. */
`timescale 1ns/1ps
module vpe_bank_properties (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [15:0] i_freq,
    input wire logic [7:0] i_block,
    input wire logic [7:0] o_pickup,
    input wire logic [7:0] o_operate
);
default clocking @(posedge i_clock);
endclocking
default disable iff (i_rst);
sequence s_held;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
endsequence
a_wait_once: assert property (s_held |=> !o_avs_waitrequest)
    else $error("bus wait too long");
a_wait_first: assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest)
    else $error("bus answered without wait");
a_upper_zero: assert property (i_avs_read && !o_avs_waitrequest
    |-> o_avs_readdata[31:16] == 16'h0000)
    else $error("upper read bits set");
a_read_stands: assert property (!(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata))
    else $error("read data moved");
a_status_mirror: assert property (
    i_avs_read && !o_avs_waitrequest && i_avs_address == 8'h90
    |-> o_avs_readdata[15:0] == {$past(o_operate), $past(o_pickup)})
    else $error("status differs from outputs");
a_block_quiet: assert property ((($past(i_block) & (o_pickup | o_operate)) == 8'h00))
    else $error("blocked element active");
a_op_needs_pk: assert property ((o_operate & ~o_pickup) == 8'h00)
    else $error("operate without pickup");
a_dead_freq: assert property (i_freq == 16'h0000 [*2] |=> o_pickup[7:6] == 2'b00)
    else $error("overflux pickup at zero frequency");
endmodule // vpe_bank_properties
bind vpe_bank vpe_bank_properties i_chk (.i_clock(i_clock), .i_rst(i_rst),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_freq(i_freq), .i_block(i_block), .o_pickup(o_pickup), .o_operate(o_operate));

// ==== vpe_front_end.sv ====
/* Phasor front end model: balanced phasors from one magnitude.
   Assumes magnitudes well below 16'h4000. */
`timescale 1ns/1ps
module vpe_front_end (
    input wire logic i_clock,
    input wire logic [15:0] i_mag,
    input wire logic [15:0] i_aux,
    input wire logic [15:0] i_hz,
    output logic signed [15:0] o_ph [6],
    output logic [15:0] o_aux,
    output logic [15:0] o_freq
);
logic signed [15:0] half;
logic signed [15:0] quad;
assign half = 16'(i_mag >> 1);
// Sine of 120 degrees in Q10
assign quad = 16'((32'(i_mag) * 32'h377) >> 10);
always_ff @(posedge i_clock)
begin
    o_ph <= '{16'(i_mag), 16'h0000, -half, -quad, -half, quad};
    o_aux <= i_aux;
    o_freq <= i_hz;
end
endmodule // vpe_front_end

// ==== tb_top.sv ====
/* Self-checking bench for vpe_bank behind the front end model.
   Assumes TICK_CYCLES of 20, so one time step is 20 clocks. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_top;
logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, wreq;
logic [7:0] adr = 8'h00, blk = 8'h00, pu, op;
logic [15:0] mag = 16'h0000, aux = 16'h0000, hz = 16'h1770, ax, fq;
logic [31:0] wd = 32'h0, q, rdata;
logic signed [15:0] ph [6];
logic [7:0] ra [6] = '{8'h80, 8'h84, 8'h88, 8'h8C, 8'h90, 8'hA0};
logic [31:0] rv [6] = '{32'h42, 32'h42, 32'h1770, 32'h2, 32'h0, 32'h0};
int err_total = 0;
int cmp_count = 0;
always #20 clk = ~clk;
vpe_front_end i_fe (.i_clock(clk), .i_mag(mag), .i_aux(aux), .i_hz(hz), .o_ph(ph),
    .o_aux(ax), .o_freq(fq));
vpe_bank #(.TICK_CYCLES(20)) i_dut (.i_clock(clk), .i_rst(rst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_va_re(ph[0]), .i_va_im(ph[1]),
    .i_vb_re(ph[2]), .i_vb_im(ph[3]), .i_vc_re(ph[4]), .i_vc_im(ph[5]),
    .i_aux_voltage_input(ax), .i_freq(fq), .i_block(blk), .o_pickup(pu), .o_operate(op));
task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    adr <= a;
    wd <= {16'h0000, d};
    rd <= ~w;
    wr <= w;
    @(posedge clk);
    while (wreq !== 1'b0)
        @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
endtask
task automatic cfg(input int e, input logic [15:0] c, p, t, x);
    acc(1'b1, 8'(16 * e + 4), p);
    acc(1'b1, 8'(16 * e + 8), t);
    acc(1'b1, 8'(16 * e + 12), x);
    acc(1'b1, 8'(16 * e), c);
endtask
// Checks on the falling edge, away from output updates
task automatic ck(input string s, input int n, input logic [7:0] m, p, o);
    repeat (n) @(posedge clk);
    @(negedge clk);
    `CHK(s, p, pu & m)
    `CHK(s, o, op & m)
    @(posedge clk);
endtask
task give_verdict;
    $display("Compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
endtask
initial
begin
    repeat (6000) @(posedge clk);
    err_total++;
    give_verdict;
end
initial
begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    acc(1'b1, 8'h90, 16'hFFFF);
    acc(1'b1, 8'hA0, 16'hFFFF);
    foreach (ra[i])
    begin
        acc(1'b0, ra[i], 16'h0000);
        `CHK("reg read", rv[i], q)
    end
    cfg(1, 16'h0001, 16'h0100, 16'h0002, 16'h0000);
    mag <= 16'h0064;
    ck("ov pickup", 6, 8'h02, 8'h02, 8'h00);
    ck("ov operate", 70, 8'h02, 8'h02, 8'h02);
    acc(1'b0, 8'h90, 16'h0000);
    `CHK("status", 32'h0202, q)
    blk <= 8'h02;
    ck("ov blocked", 2, 8'h02, 8'h00, 8'h00);
    blk <= 8'h00;
    mag <= 16'h0000;
    cfg(0, 16'h0001, 16'h0100, 16'h0003, 16'h0000);
    ck("uv dead", 4, 8'h03, 8'h01, 8'h00);
    ck("uv delay", 80, 8'h01, 8'h01, 8'h01);
    acc(1'b1, 8'h0C, 16'h0080);
    ck("uv minimum", 4, 8'h01, 8'h00, 8'h00);
    mag <= 16'h0028;
    ck("uv low", 6, 8'h01, 8'h01, 8'h00);
    mag <= 16'h0064;
    ck("uv drop", 4, 8'h01, 8'h00, 8'h00);
    cfg(2, 16'h0001, 16'h0010, 16'h0000, 16'h0000);
    cfg(3, 16'h0001, 16'h0010, 16'h0000, 16'h0000);
    ck("seq quiet", 6, 8'h0C, 8'h00, 8'h00);
    cfg(6, 16'h0001, 16'h0100, 16'h0000, 16'h0000);
    ck("vhz instant", 6, 8'hC0, 8'h40, 8'h40);
    hz <= 16'h0000;
    ck("vhz no freq", 4, 8'hC0, 8'h00, 8'h00);
    hz <= 16'h1770;
    mag <= 16'h0000;
    aux <= 16'h0064;
    acc(1'b1, 8'h8C, 16'h0006);
    ck("vhz dead phases", 4, 8'hC0, 8'h00, 8'h00);
    acc(1'b1, 8'h8C, 16'h0004);
    ck("vhz aux", 4, 8'hC0, 8'h40, 8'h40);
    cfg(5, 16'h0001, 16'h0100, 16'h0000, 16'h0000);
    cfg(4, 16'h0001, 16'h0100, 16'h0000, 16'h0000);
    ck("aux high", 6, 8'h30, 8'h20, 8'h20);
    aux <= 16'h0014;
    ck("aux low", 6, 8'h30, 8'h10, 8'h10);
    give_verdict;
end
endmodule // tb_top
